//--- hdl/tmon_regs.svh
// constants of the thermal monitor address and event logic
// assumes a 100 MHz system clock
`ifndef TMON_REGS_SVH
`define TMON_REGS_SVH

`define TMON_ADDR_UPPER      4'h9
`define TMON_FULL_SCALE      9'h0ff
`define TMON_ZONE_RESET      1'b0
`define TMON_MODE_RESET      1'b0
`define TMON_POL_RESET       1'b0
`define TMON_MASK_RESET      1'b0
`define TMON_CLK_PERIOD_NS   10
`define TMON_CONV_TIME_NS    100000
`define TMON_RW_BIT          0

`endif

//--- hdl/tmon_pkg.sv
// types of the thermal monitor address and event logic
// assumes tmon_regs.svh for all numeric constants
package tmon_pkg;

    typedef struct packed {
        logic       zone;
        logic       mode;
        logic       polarity;
        logic       mask;
        logic [2:0] fault_depth;
    } tmon_cfg_t;

    typedef struct packed {
        logic       attached;
        logic       fault;
        logic [8:0] int_code;
        logic [8:0] ext_code;
    } tmon_adc_t;

    typedef enum logic [1:0] {
        TMON_RX_IDLE = 2'b00,
        TMON_RX_ADDR = 2'b01,
        TMON_RX_ACK  = 2'b11,
        TMON_RX_BUSY = 2'b10
    } tmon_rx_state_t;

endpackage

//--- hdl/tmon_sync.sv
// two-flop synchroniser for levels from outside the clock domain
// assumes inputs are stable levels or slow edges
`timescale 1ns/1ns
module tmon_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    assign q = s2_r;
endmodule

//--- hdl/tmon_addr_rx.sv
// serial bus front end: start/stop detect, address match, acknowledge
// assumes scl and sda already synchronised to clk
`timescale 1ns/1ns
module tmon_addr_rx
    import tmon_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // synchronised bus lines
    input  wire logic       scl_s,
    input  wire logic       sda_s,
    // own client address
    input  wire logic [6:0] own_addr,
    // results
    output logic            bus_busy,
    output logic            access_done,
    output logic            sda_drive
);
    tmon_rx_state_t state_r;
    logic           scl_d_r;
    logic           sda_d_r;
    logic [7:0]     shift_r;
    logic [3:0]     bit_cnt_r;
    logic           drive_r;
    logic           done_r;
    logic           scl_rise;
    logic           scl_fall;
    logic           start_c;
    logic           stop_c;

    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r   <= TMON_RX_IDLE;
            shift_r   <= 8'h00;
            bit_cnt_r <= 4'h0;
            drive_r   <= 1'b0;
        end else if (start_c) begin
            state_r   <= TMON_RX_ADDR;
            bit_cnt_r <= 4'h0;
            drive_r   <= 1'b0;
        end else if (stop_c) begin
            state_r <= TMON_RX_IDLE;
            drive_r <= 1'b0;
        end else begin
            case (state_r)
                TMON_RX_ADDR: begin
                    if (scl_rise) begin
                        shift_r   <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    // [RULE2] match own address
                    if (scl_fall && bit_cnt_r == 4'h8) begin
                        if (shift_r[7:1] == own_addr) begin
                            state_r <= TMON_RX_ACK;
                            drive_r <= 1'b1;
                        end else begin
                            state_r <= TMON_RX_IDLE;
                        end
                    end
                end
                TMON_RX_ACK: begin
                    if (scl_fall) begin
                        state_r <= TMON_RX_BUSY;
                        drive_r <= 1'b0;
                    end
                end
                default: begin
                    drive_r <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (stop_c || start_c) &&
                      (state_r == TMON_RX_ACK || state_r == TMON_RX_BUSY);
        end
    end

    assign bus_busy    = (state_r == TMON_RX_ACK) || (state_r == TMON_RX_BUSY);
    assign access_done = done_r;
    assign sda_drive   = drive_r;
endmodule

//--- hdl/tmon_top.sv
// thermal monitor: client address, conversion sequencing, event output
// assumes analog front end supplies codes and fault flags; pins are async
`timescale 1ns/1ns
`include "tmon_regs.svh"

// Behaviour
// [RULE1] client address is fixed upper nibble plus three strap bits
// [RULE2] only a matching address starts a transaction; others ignored
// [RULE3] remote diode on the shared pin reads address bit 2 as zero
// [RULE4] results are two's complement, sign bit set means below zero
// [RULE5] conversion result is nine bits wide
// [RULE6] event when result above setpoint or below hysteresis threshold
// [RULE7] zone select one uses external diode, zero uses on-chip sensor
// [RULE8] zone select resets to zero, internal sensor monitored first
// [RULE9] zone change restarts conversion, then status and output update
// [RULE10] output follows mode and polarity bits
// [RULE11] mask set means the event pin never pulls low
// [RULE12] event pin is open drain, never driven high
// [RULE13] open or shorted diode forces full-scale result
// [RULE14] forced full scale gives event when setpoint at or below 127.0
// [RULE15] external result stays all-ones positive while fault persists
// [RULE16] diode fault reported only after fault-count conversions
// [RULE17] host makes the serial clock; device only receives it
// [RULE18] serial data is open drain on all parties with pull-up
// [RULE19] one result step is half a degree
// [RULE20] bus access aborts conversion; new one starts after access
// [RULE21] host uses only pointer values zero to three
// [RULE22] compare and status update only on a completed conversion; sticky mode also clears status on a finished access
module tmon_top
    import tmon_pkg::*;
#(
    parameter int CONV_TIME_NS = `TMON_CONV_TIME_NS,
    parameter int CONV_CYC     = (CONV_TIME_NS + `TMON_CLK_PERIOD_NS - 1) / `TMON_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // serial bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // address straps
    input  wire logic       addr2_or_remote_diode_pin,
    input  wire logic       addr_strap_bit1,
    input  wire logic       addr_strap_bit0,
    // analog front end
    input  wire tmon_adc_t  adc_in,
    // configuration
    input  wire tmon_cfg_t  cfg_in,
    input  wire logic [8:0] setpoint,
    input  wire logic [8:0] hysteresis_threshold,
    // event pin
    output logic            event_out,
    output logic            event_oe_n,
    // status
    output logic [8:0]      temp_result,
    output logic            event_status,
    output logic            diode_fault_rep,
    output logic [6:0]      client_addr,
    output logic            conv_done
);
    localparam logic [31:0] CONV_INT = 32'(CONV_CYC);
    localparam logic [31:0] CONV_EXT = 32'(2 * CONV_CYC);

    // synchronised pins
    logic       scl_s;
    logic       sda_s;
    logic [2:0] strap_s;
    tmon_adc_t  adc_s;
    tmon_cfg_t  cfg_s;
    logic [8:0] set_s;
    logic [8:0] hyst_s;

    tmon_sync #(.W(2)) u_sync_bus (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({scl_in, sda_in}),
        .q       ({scl_s, sda_s})
    );

    tmon_sync #(.W(3)) u_sync_strap (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({addr2_or_remote_diode_pin, addr_strap_bit1, addr_strap_bit0}),
        .q       (strap_s)
    );

    tmon_sync #(.W($bits(tmon_adc_t))) u_sync_adc (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       (adc_in),
        .q       (adc_s)
    );

    tmon_sync #(.W($bits(tmon_cfg_t) + 18)) u_sync_cfg (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({cfg_in, setpoint, hysteresis_threshold}),
        .q       ({cfg_s, set_s, hyst_s})
    );

    // strap capture after reset release
    logic       rst_d_r;
    logic [1:0] settle_r;
    logic       addr_lock_r;
    logic [6:0] client_addr_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_d_r  <= 1'b1;
            settle_r <= 2'h0;
        end else begin
            rst_d_r <= 1'b0;
            if (settle_r != 2'h3) begin
                settle_r <= settle_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_lock_r   <= 1'b0;
            client_addr_r <= {`TMON_ADDR_UPPER, 3'h0};
        end else if (!addr_lock_r && settle_r == 2'h3) begin
            addr_lock_r <= 1'b1;
            // [RULE1] upper pattern plus straps
            // [RULE3] diode forces bit 2 low
            client_addr_r <= {`TMON_ADDR_UPPER, strap_s[2] & ~adc_s.attached, strap_s[1:0]};
        end
    end

    // serial front end
    logic bus_busy;
    logic access_done;
    logic sda_drive;

    tmon_addr_rx u_rx (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .scl_s       (scl_s),
        .sda_s       (sda_s),
        .own_addr    (client_addr_r),
        .bus_busy    (bus_busy),
        .access_done (access_done),
        .sda_drive   (sda_drive)
    );

    // zone and config tracking
    logic zone_r;
    logic zone_chg;

    // [RULE8] zone resets internal
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            zone_r <= `TMON_ZONE_RESET;
        end else begin
            zone_r <= cfg_s.zone;
        end
    end

    assign zone_chg = (zone_r != cfg_s.zone) && !rst_d_r;

    // conversion sequencer
    logic [31:0] conv_cnt_r;
    logic [31:0] conv_len;
    logic        conv_end;

    // [RULE7] external zone twice as long
    assign conv_len = zone_r ? CONV_EXT : CONV_INT;
    assign conv_end = !bus_busy && !zone_chg && (conv_cnt_r == conv_len - 32'h1);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_cnt_r <= 32'h0;
        // [RULE20] abort on access
        end else if (bus_busy) begin
            conv_cnt_r <= 32'h0;
        // [RULE9] restart on zone change
        end else if (zone_chg) begin
            conv_cnt_r <= 32'h0;
        end else if (conv_end) begin
            conv_cnt_r <= 32'h0;
        end else begin
            conv_cnt_r <= conv_cnt_r + 32'h1;
        end
    end

    // diode fault qualification
    logic [2:0] fault_cnt_r;
    logic [2:0] depth;
    logic       fault_forced_r;

    assign depth = (cfg_s.fault_depth == 3'h0) ? 3'h1 : cfg_s.fault_depth;

    // [RULE16] fault after depth conversions
    always_ff @(posedge clk) begin
        if (sys_rst || zone_chg) begin
            fault_cnt_r    <= 3'h0;
            fault_forced_r <= 1'b0;
        end else if (conv_end) begin
            if (zone_r && adc_s.fault) begin
                if (fault_cnt_r != depth) begin
                    fault_cnt_r <= fault_cnt_r + 3'h1;
                end
                fault_forced_r <= (fault_cnt_r >= depth - 3'h1);
            end else begin
                // [RULE15] clears with fault
                fault_cnt_r    <= 3'h0;
                fault_forced_r <= 1'b0;
            end
        end
    end

    // result capture
    logic [8:0] new_code;
    logic [8:0] temp_r;
    logic       done_r;

    // [RULE7] zone picks source
    always_comb begin
        new_code = zone_r ? adc_s.ext_code : adc_s.int_code;
        // [RULE13] full scale on fault
        if (zone_r && adc_s.fault && (fault_cnt_r >= depth - 3'h1)) begin
            new_code = `TMON_FULL_SCALE;
        end
    end

    // [RULE5] nine-bit result, half degree step
    // [RULE19] lsb is half degree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            temp_r <= 9'h000;
            done_r <= 1'b0;
        end else begin
            done_r <= conv_end;
            if (conv_end) begin
                temp_r <= new_code;
            end
        end
    end

    // event compare
    logic event_now;
    logic [2:0] ev_cnt_r;
    logic ev_qual;

    // [RULE4] signed compare
    // [RULE6] above set or below hyst
    // [RULE14] full scale over low setpoint
    assign event_now = ($signed(new_code) > $signed(set_s)) ||
                       ($signed(new_code) < $signed(hyst_s));
    assign ev_qual   = event_now && (ev_cnt_r >= depth - 3'h1);

    always_ff @(posedge clk) begin
        if (sys_rst || zone_chg) begin
            ev_cnt_r <= 3'h0;
        end else if (conv_end) begin
            if (!event_now) begin
                ev_cnt_r <= 3'h0;
            end else if (ev_cnt_r != depth) begin
                ev_cnt_r <= ev_cnt_r + 3'h1;
            end
        end
    end

    // status bit
    logic status_r;

    // [RULE22] update on completion; sticky mode also clears on access_done
    // [RULE10] mode picks sticky or level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_r <= 1'b0;
        end else if (cfg_s.mode) begin
            if (conv_end && ev_qual) begin
                status_r <= 1'b1;
            end else if (access_done) begin
                status_r <= 1'b0;
            end
        end else if (conv_end) begin
            status_r <= ev_qual;
        end
    end

    // event pin
    logic ev_oe_n_r;
    logic sda_oe_n_r;
    logic ev_pull;

    // [RULE10] polarity selects level
    assign ev_pull = cfg_s.polarity ? ~status_r : status_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ev_oe_n_r <= 1'b1;
        // [RULE11] mask blocks pull-down
        end else if (cfg_s.mask) begin
            ev_oe_n_r <= 1'b1;
        end else begin
            ev_oe_n_r <= ~ev_pull;
        end
    end

    // [RULE18] open-drain data
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sda_oe_n_r <= 1'b1;
        end else begin
            sda_oe_n_r <= ~sda_drive;
        end
    end

    // registered status outputs
    logic [8:0] temp_out_r;
    logic       status_out_r;
    logic       fault_out_r;
    logic       done_out_r;
    logic       zero_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            temp_out_r   <= 9'h000;
            status_out_r <= 1'b0;
            fault_out_r  <= 1'b0;
            done_out_r   <= 1'b0;
            zero_r       <= 1'b0;
        end else begin
            temp_out_r   <= temp_r;
            status_out_r <= status_r;
            fault_out_r  <= fault_forced_r;
            done_out_r   <= done_r;
            zero_r       <= 1'b0;
        end
    end

    // [RULE12] low only, never high
    assign event_out       = zero_r;
    assign event_oe_n      = ev_oe_n_r;
    assign sda_out         = zero_r;
    assign sda_oe_n        = sda_oe_n_r;
    assign temp_result     = temp_out_r;
    assign event_status    = status_out_r;
    assign diode_fault_rep = fault_out_r;
    assign client_addr     = client_addr_r;
    assign conv_done       = done_out_r;
endmodule

//--- tb/tmon_props.sv
// concurrent checks on the thermal monitor top ports
// assumes bind from the bench; single clk domain, sync reset
`timescale 1ns/1ns
`include "tmon_regs.svh"
module tmon_props
    import tmon_pkg::*;
#(
    parameter int CONV_CYC = 20
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // watched ports
    input  wire logic       sda_out,
    input  wire logic       event_out,
    input  wire logic       event_oe_n,
    input  wire tmon_adc_t  adc_in,
    input  wire tmon_cfg_t  cfg_in,
    input  wire logic [8:0] setpoint,
    input  wire logic [8:0] hysteresis_threshold,
    input  wire logic [8:0] temp_result,
    input  wire logic       event_status,
    input  wire logic       diode_fault_rep,
    input  wire logic [6:0] client_addr,
    input  wire logic       conv_done
);
    logic [15:0] gap_cnt_r;
    logic        gap_ok_r;
    logic        zone_lo_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // cycles since last completion
    always_ff @(posedge clk) begin
        gap_cnt_r <= (sys_rst || conv_done) ? 16'h0000 : gap_cnt_r + 16'h0001;
    end
    always_ff @(posedge clk) begin
        gap_ok_r <= sys_rst ? 1'b0 : (gap_ok_r || conv_done);
    end
    always_ff @(posedge clk) begin
        zone_lo_r <= (sys_rst || conv_done) ? 1'b0 : (zone_lo_r || !cfg_in.zone);
    end

    a_event_open_drain: assert property (event_out == 1'b0)
        else $error("event pin driven high");
    a_data_open_drain: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_mask_no_pull: assert property (cfg_in.mask [*5] |-> event_oe_n)
        else $error("event pin pulled while masked");
    a_event_follow: assert property (conv_done ##0 (!cfg_in.mask && $stable(cfg_in.polarity)) [*6]
        |-> event_oe_n == (cfg_in.polarity ? event_status : !event_status))
        else $error("event pin disagrees with status and polarity");
    a_conv_spacing: assert property (conv_done && gap_ok_r |-> gap_cnt_r >= CONV_CYC - 1)
        else $error("conversion completed too early");
    a_ext_slow: assert property (conv_done && gap_ok_r && !zone_lo_r |-> gap_cnt_r >= 2 * CONV_CYC - 1)
        else $error("external conversion too short");
    a_fault_full: assert property (conv_done && diode_fault_rep |-> temp_result == `TMON_FULL_SCALE)
        else $error("fault result not full scale");
    a_status_cmp: assert property (conv_done && !cfg_in.mode && cfg_in.fault_depth <= 3'h1
        && $past(setpoint, 4) == setpoint && $past(hysteresis_threshold, 4) == hysteresis_threshold
        |-> ##2 event_status == ($signed(temp_result) > $signed(setpoint)
        || $signed(temp_result) < $signed(hysteresis_threshold)))
        else $error("status disagrees with signed compare");
    a_addr_upper: assert property (client_addr[6:3] == `TMON_ADDR_UPPER)
        else $error("client address upper bits wrong");
    a_diode_bit2: assert property (adc_in.attached [*8] |-> !client_addr[2])
        else $error("address bit 2 set with diode attached");
endmodule

//--- tb/tmon_host.sv
// serial bus host model: start, two bytes, stop
// assumes bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ns
module tmon_host (
    // serial bus
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    localparam int H = 1300;
    localparam int Q = 300;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic access(input logic [6:0] a, input logic [7:0] ptr, output logic acked);
        logic [15:0] sh;
        sh = {a, 1'b0, ptr};
        acked = 1'b0;
        sda_low = 1'b1;
        #H scl = 1'b0;
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 9; k++) begin
                #Q sda_low = (k < 8) ? !sh[15 - 8 * b - k] : 1'b0;
                #H scl = 1'b1;
                #H if (b == 0 && k == 8) acked = !sda;
                scl = 1'b0;
            end
        end
        #Q sda_low = 1'b1;
        #H scl = 1'b1;
        #H sda_low = 1'b0;
        #H;
    endtask
endmodule

//--- tb/tmon_top_bench.sv
// bench for the thermal monitor top
// assumes host model drives the bus; inputs change at falling edge
`timescale 1ns/1ns
module tmon_top_bench;
    import tmon_pkg::*;
    localparam int CONV_CYC = 20;
    logic       clk = 1'b0;
    logic       sys_rst, scl, host_low, a2, a1, a0, ack;
    logic       sda, sda_out, sda_oe_n, event_out, event_oe_n, event_status, diode_fault_rep, conv_done;
    tmon_adc_t  adc;
    tmon_cfg_t  cfg;
    logic [8:0] setp, hyst, temp_result;
    logic [6:0] client_addr;
    int         error_cnt, num_checks, t;
    int         run_cnt = 0;
    int         longest = 0;
    logic [8:0] codes [5] = '{9'h0a1, 9'h0a0, 9'h095, 9'h1d8, 9'h096};
    logic       exps [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    always #5 clk = ~clk;
    // longest stretch without a completion
    always @(negedge clk) begin
        run_cnt = (conv_done === 1'b1) ? 0 : run_cnt + 1;
        longest = (run_cnt > longest) ? run_cnt : longest;
    end
    // data wire with pull-up
    assign sda = (!sda_oe_n ? sda_out : 1'b1) && !host_low;

    tmon_host i_tmon_host (.scl(scl), .sda_low(host_low), .sda(sda));
    tmon_top #(.CONV_TIME_NS(200)) i_tmon_top (
        .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr2_or_remote_diode_pin(a2), .addr_strap_bit1(a1), .addr_strap_bit0(a0), .adc_in(adc),
        .cfg_in(cfg), .setpoint(setp), .hysteresis_threshold(hyst), .event_out(event_out),
        .event_oe_n(event_oe_n), .temp_result(temp_result), .event_status(event_status),
        .diode_fault_rep(diode_fault_rep), .client_addr(client_addr), .conv_done(conv_done));

    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_done(input int n);
        for (int k = 0; k < n; k++) begin
            t = 0;
            while (conv_done !== 1'b1 && t < 500) begin
                @(negedge clk);
                t++;
            end
            if (t >= 500) begin
                chk("conv_done", 9'h001, 9'h000);
                tally_and_finish();
            end
            @(negedge clk);
        end
        repeat (3) @(negedge clk);
    endtask

    task automatic reset_dut();
        sys_rst = 1'b1;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        repeat (12) @(negedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        error_cnt = 0;
        num_checks = 0;
        {a2, a1, a0} = 3'b101;
        adc = '{attached: 1'b0, fault: 1'b0, int_code: 9'h032, ext_code: 9'h0fa};
        cfg = '{zone: 1'b0, mode: 1'b0, polarity: 1'b0, mask: 1'b0, fault_depth: 3'h0};
        setp = 9'h0a0;
        hyst = 9'h096;
        reset_dut();
        chk("client_addr", 9'h04d, {2'b00, client_addr});
        i_tmon_host.access(7'h4c, 8'h03, ack);
        chk("ack other", 9'h001, {8'h00, sda});
        chk("ack other", 9'h000, {8'h00, ack});
        i_tmon_host.access(7'h4d, 8'h00, ack);
        chk("ack own", 9'h001, {8'h00, ack});
        wait_done(1);
        chk("restart gap", 9'h001, {8'h00, longest > 4 * CONV_CYC});
        chk("temp internal", 9'h032, temp_result);
        cfg.zone = 1'b1;
        wait_done(2);
        chk("temp external", 9'h0fa, temp_result);
        cfg.zone = 1'b0;
        for (int i = 0; i < 5; i++) begin
            adc.int_code = codes[i];
            hyst = (i == 3) ? 9'h1ce : 9'h096;
            wait_done(2);
            chk("event_status", {8'h00, exps[i]}, {8'h00, event_status});
            chk("event_oe_n", {8'h00, !exps[i]}, {8'h00, event_oe_n});
        end
        adc.int_code = 9'h0a1;
        cfg.polarity = 1'b1;
        wait_done(2);
        chk("event_oe_n high", 9'h001, {8'h00, event_oe_n});
        cfg.polarity = 1'b0;
        cfg.mask = 1'b1;
        wait_done(2);
        chk("event_oe_n masked", 9'h001, {8'h00, event_oe_n});
        cfg.mask = 1'b0;
        cfg.mode = 1'b1;
        adc.int_code = 9'h098;
        wait_done(2);
        chk("sticky status", 9'h001, {8'h00, event_status});
        i_tmon_host.access(7'h4d, 8'h01, ack);
        wait_done(2);
        chk("cleared status", 9'h000, {8'h00, event_status});
        cfg = '{zone: 1'b1, mode: 1'b0, polarity: 1'b0, mask: 1'b0, fault_depth: 3'h2};
        setp = 9'h0fe;
        wait_done(2);
        adc.fault = 1'b1;
        wait_done(1);
        chk("fault early", 9'h000, {8'h00, diode_fault_rep});
        wait_done(1);
        chk("temp fault", 9'h0ff, temp_result);
        chk("fault rep", 9'h001, {8'h00, diode_fault_rep});
        wait_done(1);
        chk("fault event", 9'h001, {8'h00, event_status});
        adc.fault = 1'b0;
        wait_done(2);
        chk("temp recovered", 9'h0fa, temp_result);
        adc.attached = 1'b1;
        {a2, a1, a0} = 3'b111;
        reset_dut();
        chk("client_addr diode", 9'h04b, {2'b00, client_addr});
        i_tmon_host.access(7'h4b, 8'h02, ack);
        chk("ack diode", 9'h001, {8'h00, ack});
        tally_and_finish();
    end
endmodule

bind tmon_top tmon_props #(.CONV_CYC(CONV_CYC)) i_tmon_props (
    .clk(clk), .sys_rst(sys_rst), .sda_out(sda_out), .event_out(event_out), .event_oe_n(event_oe_n),
    .adc_in(adc_in), .cfg_in(cfg_in), .setpoint(setpoint), .hysteresis_threshold(hysteresis_threshold),
    .temp_result(temp_result), .event_status(event_status), .diode_fault_rep(diode_fault_rep),
    .client_addr(client_addr), .conv_done(conv_done));
